/* src/afe_formatter.sv */
// Purpose: configuration registers, code mapping and multiplexed output of the front end
// Assumes: conversion result arrives as a signed scaled value with a strobe
// Notes: pixel sync and cycle pin are pins and pass a three-stage synchroniser
module afe_formatter
  import afe_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // register port
  input  wire logic [3:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [15:0]             reg_rdata,
  // pins
  input  wire logic                    pixel_sync,
  input  wire logic                    clamp_cycle_pin,
  // conversion result, signed scaled code
  input  wire logic signed [17:0]      adc_scaled,
  input  wire logic                    adc_valid,
  output logic                         adc_ready,
  // analogue path controls
  output logic                         sample_strobe,
  output logic      [1:0]              active_colour,
  output logic      [7:0]              offset_code,
  output logic      [8:0]              gain_code,
  output logic                         gain_law_bit,
  output logic                         double_sampling_bit,
  output logic      [1:0]              reset_sample_position,
  output logic      [3:0]              clamp_level_code,
  output logic                         clamp_dac_range_extend,
  output logic                         clamp_external_select,
  // output bus
  output logic      [7:0]              output_bus,
  output logic                         output_valid
);
  import afe_pkg::*;

  // ---------------- registers
  logic [15:0] setup_reg, next_setup_reg;
  logic [5:0]  clamp_reg, next_clamp_reg;
  logic [3:0]  mux_reg, next_mux_reg;
  logic [7:0]  offs [3];
  logic [8:0]  gains [3];
  logic [7:0]  next_offs [3];
  logic [8:0]  next_gains [3];
  logic [15:0] next_reg_rdata;
  logic        cyc_reset;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] base, input int idx);
    hit = a == (base + 4'(idx));
  endfunction

  always_comb begin
    next_setup_reg = setup_reg;
    next_clamp_reg = clamp_reg;
    next_mux_reg   = mux_reg;
    next_offs      = offs;
    next_gains     = gains;
    cyc_reset      = 1'b0;
    if (reg_wr) begin
      if (reg_addr == AFE_REG_SETUP) next_setup_reg = reg_wdata;
      if (reg_addr == AFE_REG_CLAMP) next_clamp_reg = reg_wdata[5:0];
      if (reg_addr == AFE_REG_MUX)   next_mux_reg   = reg_wdata[3:0];
      if (reg_addr == AFE_REG_CYC_RST) cyc_reset    = 1'b1;
      for (int i = 0; i < 3; i++) begin
        if (hit(reg_addr, AFE_REG_OFFSET0, i)) next_offs[i]  = reg_wdata[7:0];
        if (hit(reg_addr, AFE_REG_GAIN0, i))   next_gains[i] = reg_wdata[8:0];
      end
    end
  end

  // ---------------- pin synchronisers
  logic [2:0] sync_sh, cyc_sh;
  logic       sync_lvl, cyc_lvl, next_sync_lvl, next_cyc_lvl;
  logic       sync_fall, cyc_rise;
  always_comb begin
    next_sync_lvl = (sync_sh[1] == sync_sh[2]) ? sync_sh[2] : sync_lvl;
    next_cyc_lvl  = (cyc_sh[1] == cyc_sh[2]) ? cyc_sh[2] : cyc_lvl;
    sync_fall     = sync_lvl && !next_sync_lvl;
    cyc_rise      = !cyc_lvl && next_cyc_lvl;
  end

  // ---------------- colour selection, with cycle-pin stepping in line mode
  logic [1:0] auto_col, next_auto_col, next_colour;
  always_comb begin
    next_auto_col = auto_col;
    if (cyc_reset) begin
      next_auto_col = COL_RED;
    end else if (cyc_rise && mux_reg[MUX_ACYC]) begin
      next_auto_col = (auto_col == COL_BLUE) ? COL_RED : auto_col + 2'h1;
    end
    if (!setup_reg[SETUP_LBL]) begin
      next_colour = mux_reg[MUX_INTM +: 2];
    end else if (mux_reg[MUX_ACYC] && !mux_reg[MUX_FME]) begin
      next_colour = next_auto_col;
    end else begin
      next_colour = mux_reg[MUX_INTM +: 2];
    end
    if (next_colour > COL_BLUE) next_colour = COL_RED;
  end

  // ---------------- code mapping
  logic signed [18:0] mapped;
  logic [15:0]        clipped, coded;
  always_comb begin
    case (setup_reg[SETUP_BLK +: 2])
      BLK_TOP:    mapped = 19'(adc_scaled) + 19'(AFE_FULL_CODE);
      BLK_BOTTOM: mapped = 19'(adc_scaled);
      default:    mapped = 19'(adc_scaled) + 19'(AFE_MID_CODE);
    endcase
    if (mapped < 0) clipped = '0;
    else if (mapped > $signed(19'(AFE_FULL_CODE))) clipped = AFE_MAX_CODE;
    else clipped = mapped[15:0];
    coded = setup_reg[SETUP_INV] ? AFE_MAX_CODE - clipped : clipped;
  end

  logic        f_valid, f_ready;
  logic [15:0] f_data;
  afe_fifo #(.WIDTH(AFE_CODE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (adc_valid),
    .in_data   (coded),
    .in_ready  (adc_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_ready)
  );

  // ---------------- output sequencer
  afe_state_type state, next_state;
  // one bit wider than the field so that field 3 plus the base wait does not wrap to zero
  logic [2:0]  lat_cnt, next_lat_cnt;
  logic [1:0]  part, next_part;
  logic [15:0] word, next_word;
  logic [7:0]  next_bus;
  logic        next_out_valid;
  logic        nibble;
  always_comb begin
    nibble         = setup_reg[SETUP_FMT +: 2] == FMT_NIBBLE;
    next_state     = state;
    next_lat_cnt   = lat_cnt;
    next_part      = part;
    next_word      = word;
    next_bus       = output_bus;
    next_out_valid = 1'b0;
    f_ready        = 1'b0;
    case (state)
      AFE_IDLE_type_s: begin
        if (sync_fall) begin
          next_lat_cnt = 3'(setup_reg[SETUP_LAT +: 2]) + 3'(AFE_BASE_LAT);
          next_state   = AFE_WAIT_type_s;
        end
      end
      AFE_WAIT_type_s: begin
        if (lat_cnt > 3'h1) begin
          next_lat_cnt = lat_cnt - 3'h1;
        end else if (f_valid) begin
          f_ready    = 1'b1;
          next_word  = f_data;
          next_part  = '0;
          next_state = AFE_SEND_type_s;
        end else begin
          next_state = AFE_IDLE_type_s;
        end
      end
      AFE_SEND_type_s: begin
        next_out_valid = 1'b1;
        if (nibble) begin
          next_bus = {word[15 - 4 * part -: 4], 4'h0};
        end else begin
          next_bus = part[0] ? word[7:0] : word[15:8];
        end
        next_part = part + 2'h1;
        if ((nibble && part == 2'h3) || (!nibble && part == 2'h1)) begin
          next_state = AFE_GAP_type_s;
        end
      end
      AFE_GAP_type_s: begin
        next_state = AFE_IDLE_type_s;
      end
      default: next_state = AFE_IDLE_type_s;
    endcase
  end

  // ---------------- read mux
  always_comb begin
    next_reg_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        AFE_REG_SETUP:  next_reg_rdata = setup_reg;
        AFE_REG_CLAMP:  next_reg_rdata = {10'h000, clamp_reg};
        AFE_REG_MUX:    next_reg_rdata = {12'h000, mux_reg};
        AFE_REG_STATUS: next_reg_rdata = {10'h000, f_valid, adc_ready, state};
        default: begin
          for (int i = 0; i < 3; i++) begin
            if (hit(reg_addr, AFE_REG_OFFSET0, i)) next_reg_rdata = {8'h00, offs[i]};
            if (hit(reg_addr, AFE_REG_GAIN0, i))   next_reg_rdata = {7'h00, gains[i]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_reg   <= AFE_SETUP_RESET;
      clamp_reg   <= '0;
      mux_reg     <= '0;
      offs        <= '{default: AFE_OFFSET_RESET};
      gains       <= '{default: AFE_GAIN_RESET};
      reg_rdata   <= '0;
      sync_sh     <= '0;
      cyc_sh      <= '0;
      sync_lvl    <= 1'b0;
      cyc_lvl     <= 1'b0;
      auto_col    <= COL_RED;
      state       <= AFE_IDLE_type_s;
      lat_cnt     <= '0;
      part        <= '0;
      word        <= '0;
      output_bus  <= '0;
      output_valid <= 1'b0;
      sample_strobe <= 1'b0;
      active_colour <= COL_RED;
      offset_code <= AFE_OFFSET_RESET;
      gain_code   <= AFE_GAIN_RESET;
      gain_law_bit <= 1'b0;
      double_sampling_bit <= 1'b1;
      reset_sample_position <= '0;
      clamp_level_code <= '0;
      clamp_dac_range_extend <= 1'b0;
      clamp_external_select <= 1'b0;
    end else begin
      setup_reg   <= next_setup_reg;
      clamp_reg   <= next_clamp_reg;
      mux_reg     <= next_mux_reg;
      offs        <= next_offs;
      gains       <= next_gains;
      reg_rdata   <= next_reg_rdata;
      sync_sh     <= {sync_sh[1:0], pixel_sync};
      cyc_sh      <= {cyc_sh[1:0], clamp_cycle_pin};
      sync_lvl    <= next_sync_lvl;
      cyc_lvl     <= next_cyc_lvl;
      auto_col    <= next_auto_col;
      state       <= next_state;
      lat_cnt     <= next_lat_cnt;
      part        <= next_part;
      word        <= next_word;
      output_bus  <= next_bus;
      output_valid <= next_out_valid;
      sample_strobe <= sync_fall;
      active_colour <= next_colour;
      offset_code <= next_offs[next_colour];
      gain_code   <= next_gains[next_colour];
      gain_law_bit <= next_setup_reg[SETUP_LAW];
      double_sampling_bit <= next_setup_reg[SETUP_CDS];
      reset_sample_position <= next_setup_reg[SETUP_RSP +: 2];
      clamp_level_code <= next_clamp_reg[CLAMP_CODE +: 4];
      clamp_dac_range_extend <= next_clamp_reg[CLAMP_RNG];
      clamp_external_select <= next_clamp_reg[CLAMP_EXT];
    end
  end
endmodule // afe_formatter

/* src/afe_pkg.sv */
// Purpose: constants shared by the output code formatter, its assertions and its bench
// Assumes: one 50 MHz clock, asynchronous active-low reset
package afe_pkg;
  localparam int          AFE_CODE_W      = 16;
  localparam logic [17:0] AFE_FULL_CODE   = 18'h0FFFF;
  localparam logic [17:0] AFE_MID_CODE    = 18'h07FFF;
  localparam logic [15:0] AFE_MAX_CODE    = 16'hFFFF;
  // register offsets on the plain port
  localparam logic [3:0]  AFE_REG_SETUP   = 4'h0;
  localparam logic [3:0]  AFE_REG_CLAMP   = 4'h1;
  localparam logic [3:0]  AFE_REG_MUX     = 4'h2;
  localparam logic [3:0]  AFE_REG_OFFSET0 = 4'h4;
  localparam logic [3:0]  AFE_REG_GAIN0   = 4'h8;
  localparam logic [3:0]  AFE_REG_STATUS  = 4'hC;
  localparam logic [3:0]  AFE_REG_CYC_RST = 4'hD;
  // setup register fields
  localparam int SETUP_INV = 0;
  localparam int SETUP_FMT = 1;
  localparam int SETUP_LAT = 3;
  localparam int SETUP_BLK = 5;
  localparam int SETUP_CDS = 7;
  localparam int SETUP_RSP = 8;
  localparam int SETUP_LAW = 10;
  localparam int SETUP_LBL = 11;
  localparam logic [15:0] AFE_SETUP_RESET = 16'h0080;
  // clamp register fields
  localparam int CLAMP_CODE = 0;
  localparam int CLAMP_RNG  = 4;
  localparam int CLAMP_EXT  = 5;
  // mux register fields
  localparam int MUX_FME  = 0;
  localparam int MUX_ACYC = 1;
  localparam int MUX_INTM = 2;
  localparam logic [1:0] FMT_NIBBLE = 2'h3;
  localparam logic [1:0] BLK_TOP    = 2'h2;
  localparam logic [1:0] BLK_BOTTOM = 2'h3;
  localparam logic [1:0] COL_RED    = 2'h0;
  localparam logic [1:0] COL_BLUE   = 2'h2;
  localparam logic [7:0] AFE_OFFSET_RESET = 8'h80;
  localparam logic [8:0] AFE_GAIN_RESET   = 9'h000;
  localparam logic [1:0] AFE_BASE_LAT     = 2'h1;
  typedef enum logic [3:0] {
    AFE_IDLE_type_s = 4'b0001,
    AFE_WAIT_type_s = 4'b0010,
    AFE_SEND_type_s = 4'b0100,
    AFE_GAP_type_s  = 4'b1000
  } afe_state_type;
endpackage : afe_pkg

/* src/afe_fifo.sv */
// Purpose: sample fifo between conversion and output multiplexer
// Assumes: single clock, flip-flop storage
// Notes: full and empty are exact; push while full is refused
module afe_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready    = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
    out_valid   = wr_ptr != rd_ptr;
    out_data    = mem[rd_ptr[AW-1:0]];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage needs no reset; empty flag hides stale words
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule // afe_fifo

/* sim/afe_formatter_props.sv */
// Purpose: port-level assertions for afe_formatter
// Assumes: setup and mux registers are mirrored here from the write strobe
// Notes: beat checks assume setup is not rewritten while a word is going out
module afe_formatter_props
  import afe_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // observed outputs
  input wire logic        sample_strobe,
  input wire logic [1:0]  active_colour,
  input wire logic        gain_law_bit,
  input wire logic        double_sampling_bit,
  input wire logic [1:0]  reset_sample_position,
  input wire logic [3:0]  clamp_level_code,
  input wire logic        clamp_dac_range_extend,
  input wire logic        clamp_external_select,
  input wire logic [7:0]  output_bus,
  input wire logic        output_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] setup_q, next_setup_q, mux_q, next_mux_q;
  logic        setup_wr, mux_wr, nib;
  assign setup_wr = reg_wr && reg_addr == AFE_REG_SETUP;
  assign mux_wr   = reg_wr && reg_addr == AFE_REG_MUX;
  assign nib      = setup_q[SETUP_FMT +: 2] == FMT_NIBBLE;
  always_comb begin
    next_setup_q = setup_wr ? reg_wdata : setup_q;
    next_mux_q   = mux_wr ? reg_wdata : mux_q;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_q <= AFE_SETUP_RESET;
      mux_q   <= 16'h0000;
    end else begin
      setup_q <= next_setup_q;
      mux_q   <= next_mux_q;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data not idle");
  setup_follow_a: assert property (setup_wr |-> ##2 {gain_law_bit, reset_sample_position, double_sampling_bit} ==
    {setup_q[SETUP_LAW], setup_q[SETUP_RSP +: 2], setup_q[SETUP_CDS]}) else $error("setup copies stale");
  clamp_read_a: assert property (reg_rd && reg_addr == AFE_REG_CLAMP |=> reg_rdata[5:0] ==
    {$past(clamp_external_select), $past(clamp_dac_range_extend), $past(clamp_level_code)}) else $error("clamp read");
  strobe_pulse_a: assert property (sample_strobe |=> !sample_strobe) else $error("strobe too long");
  byte_beats_a: assert property ($rose(output_valid) && !nib |-> output_valid[*2] ##1 !output_valid)
    else $error("byte beat count");
  nibble_beats_a: assert property ($rose(output_valid) && nib |-> output_valid[*4] ##1 !output_valid)
    else $error("nibble beat count");
  nibble_low_a: assert property (output_valid && nib |-> output_bus[3:0] == 4'h0) else $error("low lines driven");
  colour_sel_a: assert property (mux_wr && !(setup_q[SETUP_LBL] && reg_wdata[MUX_ACYC] && !reg_wdata[MUX_FME])
    |-> ##2 active_colour == (mux_q[MUX_INTM +: 2] == 2'h3 ? COL_RED : mux_q[MUX_INTM +: 2])) else $error("colour");
endmodule // afe_formatter_props
bind afe_formatter afe_formatter_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_afe_formatter_props (.sys_clk, .rst_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_strobe, .active_colour, .gain_law_bit,
  .double_sampling_bit, .reset_sample_position, .clamp_level_code, .clamp_dac_range_extend,
  .clamp_external_select, .output_bus, .output_valid);

/* sim/afe_scanner_model.sv */
// Purpose: scanner controller model that assembles output words
// Assumes: beats of one word come back to back while output_valid is high
// Notes: a low output_valid restarts assembly, so a torn word is never counted
module afe_scanner_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // capture side
  input  wire logic [7:0]  output_bus,
  input  wire logic        output_valid,
  input  wire logic        nib,
  output logic      [15:0] word,
  output logic      [7:0]  cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] acc, next_acc;
  logic [1:0]  beat;
  assign next_acc = nib ? {acc[11:0], output_bus[7:4]} : {acc[7:0], output_bus};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc  <= 16'h0000;
      beat <= 2'h0;
      word <= 16'h0000;
      cnt  <= 8'h00;
    end else if (!output_valid) begin
      beat <= 2'h0;
    end else begin
      acc  <= next_acc;
      beat <= beat + 2'h1;
      if (beat == (nib ? 2'h3 : 2'h1)) begin
        word <= next_acc;
        cnt  <= cnt + 8'h01;
        beat <= 2'h0;
      end
    end
  end
endmodule // afe_scanner_model

/* sim/tb.sv */
// Purpose: self-checking bench for the formatter, its fifo and the bus capture
// Assumes: one word in flight per sync, so no sync lands while busy
// Notes: latency is judged against the zero setting, not as an absolute count
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s %h %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import afe_pkg::*;
  logic               sys_clk, rst_n, reg_wr, reg_rd, pixel_sync, clamp_cycle_pin, adc_valid, adc_ready, nib, ov_q;
  logic               sample_strobe, gain_law_bit, double_sampling_bit, clamp_dac_range_extend, clamp_external_select;
  logic               output_valid;
  logic [1:0]         active_colour, reset_sample_position;
  logic [3:0]         reg_addr, clamp_level_code;
  logic [7:0]         offset_code, output_bus, cnt;
  logic [8:0]         gain_code;
  logic [15:0]        reg_wdata, reg_rdata, word;
  logic signed [17:0] adc_scaled;
  int                 err_count, compares, cyc, t_s, t_o, d0;
  afe_formatter #(.FIFO_DEPTH(32)) u_afe_formatter (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pixel_sync, .clamp_cycle_pin, .adc_scaled, .adc_valid, .adc_ready, .sample_strobe, .active_colour,
    .offset_code, .gain_code, .gain_law_bit, .double_sampling_bit, .reset_sample_position, .clamp_level_code,
    .clamp_dac_range_extend, .clamp_external_select, .output_bus, .output_valid);
  afe_scanner_model u_afe_scanner_model (.sys_clk, .rst_n, .output_bus, .output_valid, .nib, .word, .cnt);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic smp(input logic signed [17:0] v);
    @(posedge sys_clk);
    adc_valid  <= 1'b1;
    adc_scaled <= v;
    @(posedge sys_clk);
    adc_valid  <= 1'b0;
    #1;
  endtask
  task automatic sync_get(output logic [15:0] w);
    logic [7:0] n0;
    n0 = cnt;
    @(posedge sys_clk);
    pixel_sync <= 1'b1;
    // one master clock period spans several system clocks; a one-clock pulse fails the agreement filter
    repeat (4) @(posedge sys_clk);
    pixel_sync <= 1'b0;
    for (int i = 0; i < 200 && cnt == n0; i++) @(posedge sys_clk);
    `CHK("word", n0 + 8'h01, cnt)
    w = word;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic col(input logic [1:0] c, input logic [7:0] o);
    for (int i = 0; i < 20 && active_colour !== c; i++) @(posedge sys_clk);
    @(posedge sys_clk);
    #1;
    `CHK("colour", c, active_colour)
    `CHK("offset_sel", o, offset_code)
  endtask
  function automatic logic [15:0] xp(input logic [1:0] b, input logic inv, input int v);
    int s;
    s = v + (b == BLK_BOTTOM ? 0 : b == BLK_TOP ? 65535 : 32767);
    s = s < 0 ? 0 : s > 65535 ? 65535 : s;
    return inv ? 16'(65535 - s) : 16'(s);
  endfunction
  task automatic t_reset;
    logic [15:0] v;
    rd(AFE_REG_SETUP, v);
    `CHK("setup", AFE_SETUP_RESET, v)
    rd(4'h3, v);
    `CHK("unmapped", 16'h0000, v)
    `CHK("dsb", 1'b1, double_sampling_bit)
    `CHK("offset_rst", 8'h80, offset_code)
    $display("t_reset end");
  endtask
  task automatic t_regs;
    logic [15:0] v;
    for (int c = 0; c < 3; c++) begin
      wr(AFE_REG_GAIN0 + 4'(c), 16'h0100 + 16'(c));
      wr(AFE_REG_OFFSET0 + 4'(c), 16'h0011 * 16'(c + 1));
    end
    wr(AFE_REG_CLAMP, 16'h003A);
    `CHK("clamp", 6'h3A, {clamp_external_select, clamp_dac_range_extend, clamp_level_code})
    rd(AFE_REG_CLAMP, v);
    `CHK("clamp_rd", 6'h3A, v[5:0])
    for (int c = 0; c < 3; c++) begin
      rd(AFE_REG_GAIN0 + 4'(c), v);
      `CHK("gain", 16'h0100 + 16'(c), v)
      rd(AFE_REG_OFFSET0 + 4'(c), v);
      `CHK("offset", 16'h0011 * 16'(c + 1), v)
    end
    wr(AFE_REG_SETUP, 16'h0700);
    `CHK("setup1", 4'hE, {gain_law_bit, reset_sample_position, double_sampling_bit})
    wr(AFE_REG_SETUP, 16'h0280);
    `CHK("setup2", 4'h5, {gain_law_bit, reset_sample_position, double_sampling_bit})
    $display("t_regs end");
  endtask
  task automatic t_codes;
    logic [1:0]  bk [7] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h3, 2'h0, 2'h3};
    int          vv [7] = '{0, 100, 'h1234, -1, -5, 'h9000, 'h1234};
    logic [15:0] w;
    logic [1:0]  f;
    for (int k = 0; k < 7; k++) begin
      f   = 2'(k % 4);
      nib = f == FMT_NIBBLE;
      wr(AFE_REG_SETUP, 16'h0080 | 16'(bk[k]) << SETUP_BLK | 16'(f) << SETUP_LAT | 16'(f) << SETUP_FMT | 16'(k == 6));
      smp(18'(vv[k]));
      sync_get(w);
      `CHK("code", xp(bk[k], k == 6, vv[k]), w)
      if (k == 0) d0 = t_o - t_s;
      `CHK("latency", d0 + k % 4, t_o - t_s)
    end
    $display("t_codes end");
  endtask
  task automatic t_colour;
    wr(AFE_REG_SETUP, 16'h0880);
    wr(AFE_REG_MUX, 16'h0002);
    wr(AFE_REG_CYC_RST, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      if (k > 0) begin
        @(posedge sys_clk);
        clamp_cycle_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        clamp_cycle_pin <= 1'b0;
      end
      col(2'(k % 3), 8'h11 * 8'(k % 3 + 1));
    end
    wr(AFE_REG_MUX, 16'h0009);
    col(COL_BLUE, 8'h33);
    `CHK("gain_sel", 9'h102, gain_code)
    wr(AFE_REG_SETUP, 16'h0080);
    wr(AFE_REG_MUX, 16'h000C);
    col(COL_RED, 8'h11);
    $display("t_colour end");
  endtask
  task automatic t_fifo;
    logic [15:0] w;
    int          n;
    nib = 1'b0;
    wr(AFE_REG_SETUP, 16'h00E0);
    for (n = 0; n < 40 && adc_ready === 1'b1; n++) smp({2'b00, 8'(n), 8'(n)});
    `CHK("depth", 32, n)
    smp(18'h0FFFF);
    rd(AFE_REG_STATUS, w);
    `CHK("full", 2'b10, w[5:4])
    for (n = 0; n < 32; n++) begin
      sync_get(w);
      `CHK("fifo", {8'(n), 8'(n)}, w)
    end
    rd(AFE_REG_STATUS, w);
    `CHK("empty", 2'b01, w[5:4])
    $display("t_fifo end");
  endtask
  task automatic test_done;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (sample_strobe === 1'b1) t_s = cyc;
    if (output_valid === 1'b1 && ov_q !== 1'b1) t_o = cyc;
    ov_q = output_valid;
    if (cyc == 20000) begin
      `CHK("timeout", 1'b0, 1'b1)
      test_done;
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, pixel_sync, clamp_cycle_pin, adc_valid, nib} = 7'h00;
    reg_addr   = 4'h0;
    reg_wdata  = 16'h0000;
    adc_scaled = 18'sh00000;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_codes;
    t_colour;
    t_fifo;
    test_done;
  end
endmodule // tb
